// ===== hdl/dram_refresh_init_sequencer.sv
// refresh, init and access sequencer for a 22-bit dram array
// assumes the bus side holds access_i stable until done_o pulses
`default_nettype none
module dram_refresh_init_sequencer
  import dram_seq_pkg::*;
#(
  parameter int unsigned REFRESH_DIV = REFRESH_CYCLES,
  parameter int unsigned WAKE_N = WAKE_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire access_req_s access_i,
  input wire logic reg_req_i,
  input wire logic init_start_i,
  input wire logic power_low_n_i,
  input wire logic battery_i,
  input wire logic [DATA_W-1:0] data_in_i,
  input wire logic [CHECK_W-1:0] check_in_i,
  output array_ctl_s array_o,
  output logic [DATA_W-1:0] data_out_o,
  output logic [CHECK_W-1:0] check_out_o,
  output logic data_oe_o,
  output logic input_latch_enable_o,
  output logic [2:0] cycle_type_selector_o,
  output logic busy_o,
  output logic init_busy_o,
  output logic done_o
);
  logic [12:0] tick_cnt_q;
  logic tick;
  logic refresh_pend_q;
  logic init_pend_q;
  logic init_active_q;
  logic [7:0] row_cnt_q;
  logic [7:0] col_cnt_q;
  logic [3:0] wake_cnt_q;
  routine_e rt_q;
  routine_e rt_d;
  logic [2:0] step_q;
  logic primary;
  logic secondary;
  logic running;
  logic start;
  logic last_step;
  logic access_ok;
  logic broadcast;
  array_ctl_s ctl_q;
  array_ctl_s ctl_d;
  logic [DATA_W-1:0] latch_q;
  logic [CHECK_W-1:0] check_q;
  logic done_q;
  logic [BANK_N-1:0] bank_sel;
  logic row_phase;
  logic col_phase;
  logic ras_on;
  logic cas_win;

  assign tick = (tick_cnt_q == 13'(REFRESH_DIV - 1));
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tick_cnt_q <= 13'h0;
    end else begin
      tick_cnt_q <= tick ? 13'h0 : tick_cnt_q + 13'h1;
    end
  end

  assign running = (rt_q != RT_IDLE);
  assign access_ok = power_low_n_i && !init_active_q && !battery_i;
  always_comb begin
    rt_d = RT_IDLE;
    if (wake_cnt_q != 4'h0) begin
      rt_d = RT_WAKE;
    end else if (refresh_pend_q && !init_active_q) begin
      rt_d = RT_REFRESH;
    end else if (init_pend_q) begin
      rt_d = RT_INIT;
    end else if (access_ok && reg_req_i) begin
      rt_d = RT_REG;
    end else if (access_ok && access_i.req) begin
      if (access_i.write) begin
        rt_d = RT_WRITE;
      end else if (!access_i.protected_region && access_i.correct_off) begin
        rt_d = RT_READ_RAW;
      end else begin
        rt_d = RT_READ_CORR;
      end
    end
  end
  assign start = !running && (rt_d != RT_IDLE);
  assign last_step = primary && (step_q == STEP_LAST);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rt_q <= RT_IDLE;
      step_q <= 3'h0;
    end else if (start) begin
      rt_q <= rt_d;
      step_q <= 3'h0;
    end else if (last_step) begin
      rt_q <= RT_IDLE;
      step_q <= 3'h0;
    end else if (primary) begin
      step_q <= step_q + 3'h1;
    end
  end

  cycle_timer u_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .run_i(running),
    .primary_o(primary),
    .secondary_o(secondary)
  );

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      refresh_pend_q <= 1'b0;
      init_pend_q <= 1'b0;
      init_active_q <= 1'b0;
      wake_cnt_q <= 4'h0;
    end else begin
      // set beats clear, held till start
      // during init a tick asks next location
      refresh_pend_q <= (tick && !init_active_q) ||
                        (refresh_pend_q && !(start && rt_d == RT_REFRESH));
      init_pend_q <= (tick && init_active_q) ||
                     (init_pend_q && !(start && rt_d == RT_INIT));
      if (init_start_i && !init_active_q) begin
        init_active_q <= 1'b1;
      end else if (last_step && rt_q == RT_INIT && row_cnt_q == 8'hff
                   && col_cnt_q == 8'hff) begin
        init_active_q <= 1'b0;
      end
      if (!done_q && wake_cnt_q == 4'h0 && rt_q == RT_IDLE && step_q == 3'h0
          && tick_cnt_q == 13'h0 && row_cnt_q == 8'h0 && !init_active_q) begin
        wake_cnt_q <= 4'(WAKE_N);
      end else if (last_step && rt_q == RT_WAKE && wake_cnt_q != 4'h0) begin
        wake_cnt_q <= wake_cnt_q - 4'h1;
      end
    end
  end

  // row counter steps 128 on refresh
  // row and column together cover 64K
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      row_cnt_q <= 8'h0;
      col_cnt_q <= 8'h0;
    end else if (last_step && (rt_q == RT_REFRESH || rt_q == RT_WAKE)) begin
      row_cnt_q <= (row_cnt_q == 8'(ROW_COUNT - 1)) ? 8'h0 : row_cnt_q + 8'h1;
    end else if (last_step && rt_q == RT_INIT) begin
      row_cnt_q <= row_cnt_q + 8'h1;
      if (row_cnt_q == 8'hff) begin
        col_cnt_q <= col_cnt_q + 8'h1;
      end
    end
  end

  // refresh, wake and init hit every bank
  assign broadcast = (rt_q == RT_REFRESH) || (rt_q == RT_INIT) || (rt_q == RT_WAKE);
  assign bank_sel = broadcast ? {BANK_N{1'b1}} : 8'(1 << access_i.bank);
  assign row_phase = running && step_q < 3'h2;
  assign col_phase = running && step_q >= 3'h2 && step_q < 3'h5;
  // battery backup takes ras from tick
  assign ras_on = battery_i ? (rt_q == RT_REFRESH && running) :
                  (running && step_q >= 3'h1 && step_q < 3'h5);
  // cas opens on the secondary phase of step 3 and stays low through step 4;
  // a gap inside the window would give a second write strobe
  assign cas_win = (step_q == 3'h3 && (secondary || primary)) || step_q == 3'h4;
  always_comb begin
    ctl_d = ctl_q;
    ctl_d.ras_n = ras_on ? ~bank_sel : {BANK_N{1'b1}};
    if (!battery_i) begin
      if (broadcast) begin
        ctl_d.addr = row_phase ? row_cnt_q : col_cnt_q;
      end else begin
        ctl_d.addr = row_phase ? access_i.addr[7:0] : access_i.addr[15:8];
      end
      ctl_d.we_n = !((rt_q == RT_WRITE || rt_q == RT_INIT) && step_q >= 3'h2
                     && step_q < 3'h5);
      ctl_d.cas_n = !(col_phase && cas_win &&
                      rt_q != RT_REFRESH && rt_q != RT_WAKE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctl_q <= '{addr: 8'h0, ras_n: {BANK_N{1'b1}}, cas_n: 1'b1, we_n: 1'b1};
      latch_q <= 16'h0;
      check_q <= 6'h0;
      done_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      if (input_latch_enable_o) begin
        latch_q <= data_in_i;
        check_q <= (rt_q == RT_WRITE) ? check_gen(data_in_i) : check_in_i;
      end else if (rt_q == RT_INIT) begin
        latch_q <= INIT_DATA;
        check_q <= INIT_CHECK;
      end
      done_q <= done_q || (last_step && rt_q == RT_WAKE && wake_cnt_q == 4'h1);
    end
  end

  // 16 data plus 6 check stored
  // reads latch once cas has data up
  assign input_latch_enable_o = running && primary &&
                                ((rt_q == RT_WRITE && step_q == 3'h1) ||
                                 ((rt_q == RT_READ_CORR || rt_q == RT_READ_RAW) &&
                                  step_q == 3'h4));
  assign array_o = ctl_q;
  assign data_out_o = latch_q;
  assign check_out_o = check_q;
  assign data_oe_o = !ctl_q.we_n;
  assign cycle_type_selector_o = rt_q;
  assign busy_o = running;
  assign init_busy_o = init_active_q;
  assign done_o = last_step && (rt_q == RT_READ_CORR || rt_q == RT_READ_RAW ||
                                rt_q == RT_WRITE || rt_q == RT_REG);
endmodule
`default_nettype wire

// ===== hdl/dram_seq_pkg.sv
// constants, types and cycle codes for the dram refresh/init sequencer
// assumes a single 20 MHz clock domain with synchronous active-low reset
//
// What this block does
// - cycle timer primary phase period 110 ns
// - secondary phase same period, 60 ns later
// - timer runs only during granted cycles
// - unprotected, correction off: no-correct routine
// - routine start from combined select inputs
// - one routine step per timer pulse
// - power low blocks access, refresh continues
// - battery backup: ras from refresh tick
// - refresh request every 13.3 us, latched
// - all 128 rows within two milliseconds
// - refresh and access mutually wait
// - two 8-bit counters, row steps 128
// - init writes zero data, checks 001100
// - init covers 64K, all strobes together
// - init blocks access; tick per location
// - write enable precedes cas; read cas only
// - 16 address bits, row half then column
// - extra ras-only cycles at power up
// - stored word is 16 data plus 6 check
// - input latch enable captures 16 data bits
// - refresh and init strobe all eight banks
// - six check bits generated per write
`default_nettype none
package dram_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PRIMARY_PERIOD_NS = 110;
  localparam int unsigned SECONDARY_OFFSET_NS = 60;
  localparam int unsigned REFRESH_PERIOD_NS = 13300;
  // least times round up, never below one cycle
  localparam int unsigned STEP_CYCLES =
    (PRIMARY_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEC_CYCLES =
    (SECONDARY_OFFSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned ROW_COUNT = 128;
  localparam int unsigned WAKE_CYCLES = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CHECK_W = 6;
  localparam int unsigned WORD_W = DATA_W + CHECK_W;
  localparam int unsigned ADDR_HALF_W = 8;
  localparam int unsigned BANK_N = 8;
  localparam logic [5:0] INIT_CHECK = 6'h0c;
  localparam logic [15:0] INIT_DATA = 16'h0000;
  localparam logic [2:0] STEP_LAST = 3'h5;

  // routine codes formed from the selection inputs
  typedef enum logic [2:0] {
    RT_IDLE = 3'b000,
    RT_REFRESH = 3'b001,
    RT_INIT = 3'b010,
    RT_WAKE = 3'b011,
    RT_READ_CORR = 3'b100,
    RT_READ_RAW = 3'b101,
    RT_WRITE = 3'b110,
    RT_REG = 3'b111
  } routine_e;

  typedef struct packed {
    logic [ADDR_HALF_W-1:0] addr;
    logic [BANK_N-1:0] ras_n;
    logic cas_n;
    logic we_n;
  } array_ctl_s;

  typedef struct packed {
    logic req;
    logic write;
    logic protected_region;
    logic correct_off;
    logic [2:0] bank;
    logic [15:0] addr;
  } access_req_s;

  function automatic logic [CHECK_W-1:0] check_gen(input logic [DATA_W-1:0] d);
    logic [CHECK_W-1:0] c;
    // msb first: cx c0 c1 c2 c4 c8, so a zero word gives INIT_CHECK
    c[5] = ^(d & 16'h4b2e);
    c[4] = ^(d & 16'h1557);
    c[3] = ~^(d & 16'ha699);
    c[2] = ~^(d & 16'h38e3);
    c[1] = ^(d & 16'hc0fc);
    c[0] = ^(d & 16'hff00);
    return c;
  endfunction
endpackage
`default_nettype wire

// ===== hdl/cycle_timer.sv
// gated two-phase step timer for the sequencer
// assumes clk_i at 20 MHz, synchronous active-low reset
`default_nettype none
module cycle_timer
  import dram_seq_pkg::*;
#(
  parameter int unsigned PERIOD = STEP_CYCLES,
  parameter int unsigned OFFSET = SEC_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  output logic primary_o,
  output logic secondary_o
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic primary_q;
  logic secondary_q;
  assign cnt_d = !run_i ? 4'h0 :
                 (cnt_q == 4'(PERIOD - 1)) ? 4'h0 : cnt_q + 4'h1;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 4'h0;
      primary_q <= 1'b0;
      secondary_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      primary_q <= run_i && (cnt_q == 4'(PERIOD - 1));
      secondary_q <= run_i && (cnt_q == 4'(OFFSET - 1));
    end
  end
  assign primary_o = primary_q;
  assign secondary_o = secondary_q;
endmodule
`default_nettype wire

// ===== tb/dram_seq_asserts.sv
// port checker for the refresh/init sequencer
// assumes one clock and a sync active-low reset
`default_nettype none
module dram_seq_asserts
  import dram_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic power_low_n_i,
  input wire logic battery_i,
  input wire array_ctl_s array_o,
  input wire logic input_latch_enable_o,
  input wire logic data_oe_o,
  input wire logic [2:0] cycle_type_selector_o,
  input wire logic busy_o,
  input wire logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic acc_sel = cycle_type_selector_o[2];
  wire logic strobes_off = &array_o.ras_n && array_o.cas_n && array_o.we_n;
  sequence s_acc_start;
    $rose(busy_o) && acc_sel;
  endsequence
  sequence s_blocked_start;
    $rose(busy_o) && (!$past(power_low_n_i) || $past(battery_i));
  endsequence
  a_done_timing: assert property (s_acc_start |-> ##[14:20] done_o)
    else $error("access routine ended late");
  a_power_blocks: assert property (s_blocked_start |-> !acc_sel)
    else $error("access started while blocked");
  a_idle_strobes: assert property (!busy_o && !$past(busy_o) && !battery_i |-> strobes_off)
    else $error("strobe active while idle");
  a_bank_single: assert property (busy_o && acc_sel |-> $onehot0(~array_o.ras_n))
    else $error("several banks strobed on access");
  a_all_banks: assert property (busy_o && !acc_sel && !(&array_o.ras_n) |-> array_o.ras_n == '0)
    else $error("refresh or init missed a bank");
  a_write_early: assert property ($fell(array_o.cas_n) && !array_o.we_n |-> $past(!array_o.we_n))
    else $error("write enable came with column strobe");
  a_battery_hold: assert property (battery_i && $past(battery_i) |->
    $stable(array_o.addr) && $stable(array_o.cas_n) && $stable(array_o.we_n))
    else $error("timing moved in battery mode");
  a_latch_pulse: assert property (input_latch_enable_o |-> acc_sel ##1 !input_latch_enable_o)
    else $error("latch enable not a single access pulse");
  a_oe_write: assert property (data_oe_o |->
    cycle_type_selector_o inside {RT_WRITE, RT_INIT})
    else $error("data driven outside a write");
endmodule
bind dram_refresh_init_sequencer dram_seq_asserts chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .power_low_n_i(power_low_n_i), .battery_i(battery_i),
  .array_o(array_o), .input_latch_enable_o(input_latch_enable_o), .data_oe_o(data_oe_o),
  .cycle_type_selector_o(cycle_type_selector_o), .busy_o(busy_o), .done_o(done_o)
);
`default_nettype wire

// ===== tb/dram_array_model.sv
// behavioural dram array, addresses latched on strobe edges
// assumes registered strobes from the sequencer
`default_nettype none
module dram_array_model
  import dram_seq_pkg::*;
(
  input wire logic clk_i,
  input wire array_ctl_s array_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [CHECK_W-1:0] wcheck_i,
  output logic [CHECK_W-1:0] rcheck_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] mem [int];
  logic [WORD_W-1:0] last_wr;
  logic [7:0] row_q;
  logic ras_q = 1'b1, cas_q = 1'b1;
  int wr_n = 0;
  wire logic [15:0] key = {array_i.addr, row_q};
  initial rcheck_o = '0;
  always @(posedge clk_i) begin
    ras_q <= &array_i.ras_n;
    cas_q <= array_i.cas_n;
    // row half on any bank strobe
    if (ras_q && !(&array_i.ras_n)) row_q <= array_i.addr;
    if (cas_q && !array_i.cas_n && !array_i.we_n) begin
      mem[key] = {wdata_i, wcheck_i};
      last_wr <= {wdata_i, wcheck_i};
      wr_n++;
    end
    // column strobe alone reads; idle lines drift
    rcheck_o <= (!array_i.cas_n && array_i.we_n && mem.exists(key)) ? mem[key][5:0] : ~rcheck_o;
  end
endmodule
`default_nettype wire

// ===== tb/dram_refresh_init_sequencer_test.sv
// self-checking bench for the refresh/init sequencer
// assumes the array model and port checker are compiled first
`default_nettype none
module dram_refresh_init_sequencer_test;
  import dram_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, resetn_i = 0, reg_req_i = 0, init_start_i = 0, power_low_n_i = 1;
  logic battery_i = 0, ile, busy_o, init_busy_o, done_o, ras_q = 1;
  access_req_s access_i = '0;
  array_ctl_s array_o;
  logic [15:0] data_in_i = '0, data_out_o, a, d;
  logic [5:0] check_out_o, check_in_i;
  logic [2:0] sel, s;
  logic [31:0] rng = 2, v;
  logic [7:0] prev_row;
  logic [15:0] wa [6];
  int fails = 0, checks = 0, wake_n = 0, ref_n = 0, row_n = 0, dones = 0, n0, r0;
  // short refresh period keeps the run brief
  dram_refresh_init_sequencer #(.REFRESH_DIV(100)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .access_i(access_i), .reg_req_i(reg_req_i),
    .init_start_i(init_start_i), .power_low_n_i(power_low_n_i), .battery_i(battery_i),
    .data_in_i(data_in_i), .check_in_i(check_in_i), .array_o(array_o),
    .data_out_o(data_out_o), .check_out_o(check_out_o), .data_oe_o(),
    .input_latch_enable_o(ile), .cycle_type_selector_o(sel), .busy_o(busy_o),
    .init_busy_o(init_busy_o), .done_o(done_o));
  dram_array_model mdl (.clk_i(clk_i), .array_i(array_o), .wdata_i(data_out_o),
    .wcheck_i(check_out_o), .rcheck_o(check_in_i));
  initial forever #25 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // check bits msb first cx c0 c1 c2 c4 c8; c1 and c2 use odd parity
  function automatic logic [5:0] exp_chk(input logic [15:0] x);
    return {^(x & 16'h4b2e), ^(x & 16'h1557), ~^(x & 16'ha699),
            ~^(x & 16'h38e3), ^(x & 16'hc0fc), ^(x & 16'hff00)};
  endfunction
  task automatic acc(input logic r, input logic w, input logic p, input logic o);
    v = rnd();
    @(posedge clk_i);
    access_i <= {!r, w, p, o, v[2:0], a};
    reg_req_i <= r;
    data_in_i <= d;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done_o !== 1'b1 && n < 600) begin
      @(negedge clk_i);
      n++;
    end
    s = sel;
    check(n < 600, 1'b1); // answered
    @(posedge clk_i);
    access_i.req <= 1'b0;
    reg_req_i <= 1'b0;
  endtask
  // wake, refresh and completion counting on settled outputs
  always @(negedge clk_i) begin
    ras_q <= &array_o.ras_n;
    if (done_o === 1'b1) dones++;
    if (ras_q && !(&array_o.ras_n) && sel === RT_WAKE) wake_n++;
    if (ras_q && !(&array_o.ras_n) && sel === RT_REFRESH) begin
      ref_n++;
      if (row_n > 0) check(array_o.addr, (prev_row + 8'h1) & 8'h7f); // next row
      prev_row = array_o.addr;
      row_n++;
    end
    // held addresses in backup must not seed the next row check
    if (init_busy_o !== 1'b0 || battery_i || !resetn_i) row_n = 0;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      v = rnd();
      a = (i == 0) ? 16'hffff : v[15:0];
      d = (i == 1) ? 16'hffff : v[31:16];
      if (i < 6) begin
        acc(0, 1, 1, 0);
        wait_done();
        check(s, RT_WRITE); // write routine
        check(mdl.mem[a][21:6], d); // stored word
        check(mdl.mem[a][5:0], exp_chk(d)); // stored check bits
        wa[i] = a;
      end else begin
        // read back an address written above
        a = wa[i - 6];
        acc(0, 0, i[0], i[1]);
        wait_done();
        check(s, (!i[0] && i[1]) ? RT_READ_RAW : RT_READ_CORR); // routine choice
        check(check_out_o, mdl.mem[a][5:0]); // read check bits
      end
    end
    check(wake_n, WAKE_CYCLES); // wake cycles
    acc(1, 0, 0, 0);
    wait_done();
    check(s, RT_REG); // register routine
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      power_low_n_i <= k[0];
      battery_i <= k[0];
      acc(0, 0, 0, 0);
      n0 = dones;
      r0 = ref_n;
      repeat (1000) @(posedge clk_i);
      check(dones, n0); // access held off
      check((ref_n - r0) inside {[9:11]}, 1'b1); // refresh continues
      power_low_n_i <= 1'b1;
      battery_i <= 1'b0;
      wait_done();
    end
    @(posedge clk_i);
    init_start_i <= 1'b1;
    acc(0, 0, 0, 0);
    init_start_i <= 1'b0;
    n0 = dones;
    r0 = mdl.wr_n;
    repeat (2000) @(posedge clk_i);
    check(init_busy_o, 1'b1); // init running
    check(dones, n0); // access held off
    check((mdl.wr_n - r0) inside {[19:21]}, 1'b1); // one write per tick
    check(mdl.last_wr, {16'h0000, 6'h0c}); // zero word
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_done();
    results();
  end
endmodule
`default_nettype wire
